/* File: hdl/ppmx_pin_mux.sv */
// Behaviour
// R1: Select bit 0 gives pins to microcontroller.
// R2: Select 1, mode 01/10 gives floppy interface.
// R3: Select 1, mode 00/11 gives host port.
// R4: Host owner state drives pins, incl power-down.
// R5: Floppy owner state drives pins, incl power-down.
// R6: Microcontroller outputs driven unless power-good low.
// R7: Software disables port DMA/IRQ without ownership.
// R8: Non-owner host data read returns last write.
// R9: Non-owner control read shows cable disconnected.
// R10: Non-owner status read: busy,pe,slct 0; ack,err 1.
// R11: Microcontroller enable bit matters only for host.
// R12: Floppy mode hides the port from host.
// R13: Floppy signals mapped onto fixed port pins.
// R14: Floppy outputs are open-drain, low only.
// R15: Mode bits choose one- or two-drive mode.
// R16: Drive swap picks which drive uses port.
// R17: Two-drive mode drives both select/motor pairs.
// R18: One-drive mode leaves the other pair inactive.
// R19: Deactivated or powered-down owner releases pins.
// R20: Floppy pins ignore port device activation state.
// R21: Floppy controller mode bits do not matter.
// R22: Code 01 one-drive, code 10 two-drive.
`timescale 1ns/1ps
`default_nettype none
module ppmx_pin_mux (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic HOST_ACCESS_SELECT,
   input wire logic [1:0] DEVICE_MODE,
   input wire logic FDC_ACTIVE,
   input wire logic FDC_POWER_DOWN,
   input wire logic PP_ACTIVE,
   input wire logic PP_POWER_DOWN,
   input wire logic DRIVE_SWAP,
   input wire logic VCC2_POWER_GOOD,
   input wire logic MCU_PP_ENABLE,
   input wire logic [ppmx_pkg::NPINS-1:0] MCU_PIN_OUT,
   input wire logic MCU_DATA_DRIVE,
   input wire logic [ppmx_pkg::NPINS-1:0] HOST_PIN_OUT,
   input wire logic [ppmx_pkg::NPINS-1:0] HOST_PIN_DRIVE,
   input wire logic HOST_DATA_WRITE,
   input wire logic [7:0] HOST_DATA_WDATA,
   input wire logic [7:0] HOST_DATA_LD,
   input wire logic [7:0] HOST_CTRL_LD,
   input wire logic [7:0] HOST_STAT_LD,
   input wire logic DRIVE0_SELECT_N,
   input wire logic DRIVE1_SELECT_N,
   input wire logic MOTOR0_ON_N,
   input wire logic MOTOR1_ON_N,
   input wire logic WRITE_PULSE_N,
   input wire logic WRITE_GATE_N,
   input wire logic DENSITY_SELECT,
   input wire logic HEAD_SELECT_N,
   input wire logic STEP_DIRECTION_N,
   input wire logic STEP_PULSE_N,
   input wire logic [ppmx_pkg::NPINS-1:0] PIN_IN,
   output logic [ppmx_pkg::NPINS-1:0] PIN_OUT,
   output logic [ppmx_pkg::NPINS-1:0] PIN_OE_N,
   output ppmx_pkg::ppmx_owner_t PIN_OWNER,
   output logic [7:0] HOST_DATA_RD,
   output logic [7:0] HOST_CTRL_RD,
   output logic [7:0] HOST_STAT_RD,
   output logic [ppmx_pkg::NPINS-1:0] MCU_PIN_IN,
   output logic INDEX_PULSE_N,
   output logic TRACK_ZERO_N,
   output logic WRITE_PROTECT_N,
   output logic READ_PULSE_N,
   output logic DISK_CHANGED_N,
   output logic MEDIA_ID_BIT0,
   output logic MEDIA_ID_BIT1
);
   import ppmx_pkg::*;

   ppmx_state_t s_q;
   ppmx_state_t s_d;
   logic fdd_mode;
   logic dual_drive;
   logic fdd_enable;
   logic host_enable;
   logic [16:0] mcu_drive;
   logic [16:0] fdd_out;
   logic [16:0] fdd_oe_n;

   // Mode 01 one drive, 10 two drives; floppy mode bits 7:6 are not inputs
   assign fdd_mode = HOST_ACCESS_SELECT && // [R2] [R15] [R21]
                     (DEVICE_MODE == MODE_ONE_DRIVE || DEVICE_MODE == MODE_TWO_DRIVE);
   assign dual_drive = (DEVICE_MODE == MODE_TWO_DRIVE); // [R22]
   // Port device activation is deliberately not looked at here
   assign fdd_enable = FDC_ACTIVE && !FDC_POWER_DOWN; // [R5] [R20]
   // Enable bit from the microcontroller only gates the host owner
   assign host_enable = PP_ACTIVE && !PP_POWER_DOWN && MCU_PP_ENABLE; // [R4] [R11]
   // Status pins are inputs in SPP use; data follows direction bit
   assign mcu_drive = VCC2_POWER_GOOD ? // [R6]
                      (MCU_OUT_PINS | (MCU_DATA_DRIVE ? MCU_DATA_PINS : PINS_ZERO)) : PINS_ZERO;

   ppmx_fdd_map u_fdd_map (
      .enable(fdd_enable),
      .dual_drive(dual_drive),
      .drive_swap(DRIVE_SWAP),
      .drive0_select_n(DRIVE0_SELECT_N),
      .drive1_select_n(DRIVE1_SELECT_N),
      .motor0_on_n(MOTOR0_ON_N),
      .motor1_on_n(MOTOR1_ON_N),
      .write_pulse_n(WRITE_PULSE_N),
      .write_gate_n(WRITE_GATE_N),
      .density_select(DENSITY_SELECT),
      .head_select_n(HEAD_SELECT_N),
      .step_direction_n(STEP_DIRECTION_N),
      .step_pulse_n(STEP_PULSE_N),
      .pin_out(fdd_out),
      .pin_oe_n(fdd_oe_n)
   );

   always_comb begin
      s_d = s_q;
      if (!HOST_ACCESS_SELECT) begin
         s_d.owner = OWN_MCU; // [R1]
      end else if (fdd_mode) begin
         s_d.owner = OWN_FDC; // [R2]
      end else begin
         s_d.owner = OWN_HOST; // [R3]
      end
      case (s_d.owner)
         OWN_MCU: begin
            s_d.pin_out = MCU_PIN_OUT; // [R1]
            s_d.pin_oe_n = ~mcu_drive; // [R6]
         end
         OWN_FDC: begin
            s_d.pin_out = fdd_out; // [R12] [R13] [R14]
            s_d.pin_oe_n = fdd_oe_n; // [R19]
         end
         OWN_HOST: begin
            if (host_enable) begin
               s_d.pin_out = HOST_PIN_OUT; // [R3] [R4]
               s_d.pin_oe_n = ~HOST_PIN_DRIVE;
            end else begin
               s_d.pin_out = PINS_ZERO; // [R19]
               s_d.pin_oe_n = PINS_RELEASED;
            end
         end
         default: begin
            s_d.pin_out = PINS_ZERO;
            s_d.pin_oe_n = PINS_RELEASED;
         end
      endcase
      // Floppy inputs idle high when the port is not the floppy's
      if (s_d.owner == OWN_FDC) begin
         s_d.fdd_in = {PIN_IN[PIN_D7], PIN_IN[PIN_D5], PIN_IN[PIN_D4], PIN_IN[PIN_D3], // [R13]
                       PIN_IN[PIN_D2], PIN_IN[PIN_D1], PIN_IN[PIN_D0]};
      end else begin
         s_d.fdd_in = FDD_IN_IDLE;
      end
      s_d.mcu_in = PIN_IN;
      // Latched under every owner so the shadow is current on hand-over
      if (HOST_DATA_WRITE) begin
         s_d.data_wr = HOST_DATA_WDATA; // [R8]
      end
      if (s_d.owner == OWN_HOST) begin
         s_d.data_rd = HOST_DATA_LD; // [R4]
         s_d.ctrl_rd = HOST_CTRL_LD;
         s_d.stat_rd = HOST_STAT_LD;
      end else begin
         s_d.data_rd = s_q.data_wr; // [R8]
         s_d.ctrl_rd = CTRL_NO_CABLE; // [R9]
         s_d.stat_rd = STAT_NO_CABLE; // [R10]
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         s_q.owner <= OWN_MCU;
         s_q.pin_out <= PINS_ZERO;
         s_q.pin_oe_n <= PINS_RELEASED;
         s_q.fdd_in <= FDD_IN_IDLE;
         s_q.mcu_in <= PINS_ZERO;
         s_q.data_wr <= BYTE_ZERO;
         s_q.data_rd <= BYTE_ZERO;
         s_q.ctrl_rd <= CTRL_NO_CABLE;
         s_q.stat_rd <= STAT_NO_CABLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign PIN_OUT = s_q.pin_out;
   assign PIN_OE_N = s_q.pin_oe_n;
   assign PIN_OWNER = s_q.owner;
   assign HOST_DATA_RD = s_q.data_rd;
   assign HOST_CTRL_RD = s_q.ctrl_rd;
   assign HOST_STAT_RD = s_q.stat_rd;
   assign MCU_PIN_IN = s_q.mcu_in;
   assign INDEX_PULSE_N = s_q.fdd_in[0];
   assign TRACK_ZERO_N = s_q.fdd_in[1];
   assign WRITE_PROTECT_N = s_q.fdd_in[2];
   assign READ_PULSE_N = s_q.fdd_in[3];
   assign DISK_CHANGED_N = s_q.fdd_in[4];
   assign MEDIA_ID_BIT0 = s_q.fdd_in[5];
   assign MEDIA_ID_BIT1 = s_q.fdd_in[6];

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   AST_OWNER_MCU: assert property ( // [R1]
      !HOST_ACCESS_SELECT |=> PIN_OWNER == OWN_MCU)
      else $error("select low did not give pins to microcontroller");

   AST_OWNER_FDC: assert property ( // [R2]
      HOST_ACCESS_SELECT && (DEVICE_MODE == MODE_ONE_DRIVE || DEVICE_MODE == MODE_TWO_DRIVE)
      |=> PIN_OWNER == OWN_FDC)
      else $error("floppy mode code did not give pins to floppy");

   AST_OWNER_HOST: assert property ( // [R3]
      HOST_ACCESS_SELECT && (DEVICE_MODE == 2'h0 || DEVICE_MODE == 2'h3)
      |=> PIN_OWNER == OWN_HOST)
      else $error("port mode code did not give pins to host");

   AST_MCU_DRIVEN: assert property ( // [R6]
      !HOST_ACCESS_SELECT && VCC2_POWER_GOOD |=> (PIN_OE_N & MCU_OUT_PINS) == PINS_ZERO
      && PIN_OUT == $past(MCU_PIN_OUT))
      else $error("microcontroller outputs not driven");

   AST_MCU_HIZ: assert property ( // [R6]
      !HOST_ACCESS_SELECT && !VCC2_POWER_GOOD |=> PIN_OE_N == PINS_RELEASED)
      else $error("pins driven without power good");

   AST_FDC_HIZ: assert property ( // [R19]
      fdd_mode && !fdd_enable |=> PIN_OE_N == PINS_RELEASED)
      else $error("inactive floppy owner still drives pins");

   AST_HOST_GATE: assert property ( // [R11]
      HOST_ACCESS_SELECT && !fdd_mode && !MCU_PP_ENABLE |=> PIN_OE_N == PINS_RELEASED)
      else $error("host pins driven with port enable off");

   AST_HOST_PASS: assert property ( // [R4]
      HOST_ACCESS_SELECT && !fdd_mode && host_enable
      |=> PIN_OE_N == ~$past(HOST_PIN_DRIVE) && PIN_OUT == $past(HOST_PIN_OUT))
      else $error("host pin state not followed");

   AST_DATA_SHADOW: assert property ( // [R8]
      HOST_DATA_WRITE && !HOST_ACCESS_SELECT ##1 !HOST_DATA_WRITE && !HOST_ACCESS_SELECT
      |=> HOST_DATA_RD == $past(HOST_DATA_WDATA, 2))
      else $error("data read is not last write");

   AST_NO_CABLE: assert property ( // [R9] [R10]
      PIN_OWNER != OWN_HOST |-> HOST_CTRL_RD == CTRL_NO_CABLE && HOST_STAT_RD == STAT_NO_CABLE)
      else $error("disconnected cable readback wrong");

   AST_OPEN_DRAIN: assert property ( // [R14]
      PIN_OWNER == OWN_FDC |-> PIN_OUT == PINS_ZERO)
      else $error("floppy output driven high");

   AST_ONE_DRIVE: assert property ( // [R18]
      fdd_mode && !dual_drive && !DRIVE_SWAP |=> PIN_OE_N[PIN_STB] && PIN_OE_N[PIN_D6])
      else $error("unused drive pair active in one-drive mode");

   AST_TWO_DRIVE: assert property ( // [R17]
      fdd_mode && dual_drive && fdd_enable && !DRIVE0_SELECT_N && !MOTOR1_ON_N
      |=> !PIN_OE_N[PIN_STB] && !PIN_OE_N[PIN_BUSY])
      else $error("two-drive select/motor not driven");

   AST_FDD_INPUT: assert property ( // [R13]
      fdd_mode |=> INDEX_PULSE_N == $past(PIN_IN[PIN_D0]) && MEDIA_ID_BIT1 == $past(PIN_IN[PIN_D7]))
      else $error("floppy input not taken from port pin");

   AST_FDD_WRITE_PINS: assert property ( // [R13] [R14]
      fdd_mode && fdd_enable |=> PIN_OE_N[PIN_PE] == $past(WRITE_PULSE_N)
      && PIN_OE_N[PIN_SLCT] == $past(WRITE_GATE_N) && PIN_OE_N[PIN_ALF] == $past(DENSITY_SELECT))
      else $error("floppy write pins not pulled low on a low signal");

   AST_FDD_HEAD_PINS: assert property ( // [R13] [R14]
      fdd_mode && fdd_enable |=> PIN_OE_N[PIN_ERR] == $past(HEAD_SELECT_N)
      && PIN_OE_N[PIN_INIT] == $past(STEP_DIRECTION_N) && PIN_OE_N[PIN_SLIN] == $past(STEP_PULSE_N))
      else $error("floppy head or step pins not pulled low on a low signal");

   AST_FDD_IN_TRACK: assert property ( // [R13]
      fdd_mode |=> TRACK_ZERO_N == $past(PIN_IN[PIN_D1]) && WRITE_PROTECT_N == $past(PIN_IN[PIN_D2])
      && READ_PULSE_N == $past(PIN_IN[PIN_D3]))
      else $error("track, protect or read input not taken from port pin");

   AST_FDD_IN_DISK: assert property ( // [R13]
      fdd_mode |=> DISK_CHANGED_N == $past(PIN_IN[PIN_D4]) && MEDIA_ID_BIT0 == $past(PIN_IN[PIN_D5]))
      else $error("disk change or media input not taken from port pin");

   AST_FDD_IN_IDLE: assert property ( // [R13]
      !fdd_mode |=> {MEDIA_ID_BIT1, MEDIA_ID_BIT0, DISK_CHANGED_N, READ_PULSE_N, WRITE_PROTECT_N,
      TRACK_ZERO_N, INDEX_PULSE_N} == FDD_IN_IDLE)
      else $error("floppy inputs not idle without floppy owner");

   AST_FDD_IN_RELEASED: assert property ( // [R13]
      PIN_OWNER == OWN_FDC |-> PIN_OE_N[PIN_D5:PIN_D0] == 6'h3F && PIN_OE_N[PIN_D7])
      else $error("floppy input pin driven");

   AST_SWAP_OFF_PAIR: assert property ( // [R16] [R18]
      fdd_mode && !dual_drive && DRIVE_SWAP |=> PIN_OE_N[PIN_ACK] && PIN_OE_N[PIN_BUSY])
      else $error("drive 1 pair active with swap set");

   AST_SWAP_PAIR0: assert property ( // [R16]
      fdd_mode && !dual_drive && DRIVE_SWAP && fdd_enable
      |=> PIN_OE_N[PIN_STB] == $past(DRIVE0_SELECT_N) && PIN_OE_N[PIN_D6] == $past(MOTOR0_ON_N))
      else $error("drive 0 pair not on port with swap set");

   AST_NOSWAP_PAIR1: assert property ( // [R16]
      fdd_mode && !dual_drive && !DRIVE_SWAP && fdd_enable
      |=> PIN_OE_N[PIN_ACK] == $past(DRIVE1_SELECT_N) && PIN_OE_N[PIN_BUSY] == $past(MOTOR1_ON_N))
      else $error("drive 1 pair not on port with swap clear");

   AST_TWO_DRIVE_ALL: assert property ( // [R17]
      fdd_mode && dual_drive && fdd_enable |=> PIN_OE_N[PIN_STB] == $past(DRIVE0_SELECT_N)
      && PIN_OE_N[PIN_D6] == $past(MOTOR0_ON_N) && PIN_OE_N[PIN_ACK] == $past(DRIVE1_SELECT_N)
      && PIN_OE_N[PIN_BUSY] == $past(MOTOR1_ON_N))
      else $error("two-drive pairs not both on port");

   AST_FDD_IGNORES_PP: assert property ( // [R20]
      fdd_mode && fdd_enable && (!PP_ACTIVE || PP_POWER_DOWN || !MCU_PP_ENABLE)
      |=> PIN_OE_N[PIN_SLIN] == $past(STEP_PULSE_N) && PIN_OE_N[PIN_PE] == $past(WRITE_PULSE_N))
      else $error("floppy pins follow port device state");

   AST_HOST_POWER_HIZ: assert property ( // [R19]
      HOST_ACCESS_SELECT && !fdd_mode && (!PP_ACTIVE || PP_POWER_DOWN) |=> PIN_OE_N == PINS_RELEASED)
      else $error("inactive host owner still drives pins");

   AST_MCU_STATUS_IN: assert property ( // [R1]
      !HOST_ACCESS_SELECT |=> (PIN_OE_N & STATUS_PINS) == STATUS_PINS)
      else $error("status pin driven under microcontroller");

   AST_MCU_DATA_DIR: assert property ( // [R1]
      !HOST_ACCESS_SELECT && VCC2_POWER_GOOD
      |=> (PIN_OE_N & MCU_DATA_PINS) == ($past(MCU_DATA_DRIVE) ? PINS_ZERO : MCU_DATA_PINS))
      else $error("data pins do not follow microcontroller direction");

   AST_MCU_IGNORES_ENABLE: assert property ( // [R11]
      !HOST_ACCESS_SELECT && VCC2_POWER_GOOD && !MCU_PP_ENABLE |=> (PIN_OE_N & MCU_OUT_PINS) == PINS_ZERO)
      else $error("port enable bit released microcontroller pins");

   AST_HOST_READBACK: assert property ( // [R4]
      HOST_ACCESS_SELECT && !fdd_mode |=> HOST_DATA_RD == $past(HOST_DATA_LD)
      && HOST_CTRL_RD == $past(HOST_CTRL_LD) && HOST_STAT_RD == $past(HOST_STAT_LD))
      else $error("host owner readback not passed through");

   AST_FDC_HIDES_HOST: assert property ( // [R12]
      fdd_mode |=> PIN_OWNER != OWN_HOST && HOST_CTRL_RD == CTRL_NO_CABLE && HOST_STAT_RD == STAT_NO_CABLE)
      else $error("port visible to host in floppy mode");

   AST_MCU_PIN_IN: assert property ( // [R1]
      1'b1 |=> MCU_PIN_IN == $past(PIN_IN))
      else $error("microcontroller pin input not registered");

   COV_FDC_ACTIVE: cover property (fdd_mode && fdd_enable ##1 PIN_OWNER == OWN_FDC);
   COV_HOST_ACTIVE: cover property (HOST_ACCESS_SELECT && !fdd_mode && host_enable ##1 PIN_OWNER == OWN_HOST);
   COV_MCU_POWER_LOSS: cover property (!HOST_ACCESS_SELECT && VCC2_POWER_GOOD ##1 !VCC2_POWER_GOOD);
   COV_SWAP_ONE_DRIVE: cover property (fdd_mode && !dual_drive && DRIVE_SWAP && fdd_enable);
   COV_TWO_DRIVE: cover property (fdd_mode && dual_drive && fdd_enable ##1 PIN_OWNER == OWN_FDC);

endmodule // ppmx_pin_mux
`default_nettype wire

/* File: hdl/ppmx_pkg.sv */
package ppmx_pkg;

   // Pin positions on the 17-pin port vector
   localparam int NPINS = 17;
   localparam int PIN_STB = 0;
   localparam int PIN_D0 = 1;
   localparam int PIN_D1 = 2;
   localparam int PIN_D2 = 3;
   localparam int PIN_D3 = 4;
   localparam int PIN_D4 = 5;
   localparam int PIN_D5 = 6;
   localparam int PIN_D6 = 7;
   localparam int PIN_D7 = 8;
   localparam int PIN_ACK = 9;
   localparam int PIN_BUSY = 10;
   localparam int PIN_PE = 11;
   localparam int PIN_SLCT = 12;
   localparam int PIN_ALF = 13;
   localparam int PIN_ERR = 14;
   localparam int PIN_INIT = 15;
   localparam int PIN_SLIN = 16;

   // Pin groups
   localparam logic [16:0] MCU_OUT_PINS = 17'h1A001;
   localparam logic [16:0] MCU_DATA_PINS = 17'h001FE;
   localparam logic [16:0] STATUS_PINS = 17'h05E00;
   localparam logic [16:0] FDD_FIXED_OUT_PINS = 17'h1F800;
   localparam logic [16:0] FDD_PAIR0_PINS = 17'h00081;
   localparam logic [16:0] FDD_PAIR1_PINS = 17'h00600;
   localparam logic [16:0] PINS_RELEASED = 17'h1FFFF;
   localparam logic [16:0] PINS_ZERO = 17'h00000;

   // Device-mode field codes
   localparam logic [1:0] MODE_ONE_DRIVE = 2'h1;
   localparam logic [1:0] MODE_TWO_DRIVE = 2'h2;

   // Readbacks while the host lacks the pins
   localparam logic [7:0] CTRL_NO_CABLE = 8'h04;
   localparam logic [7:0] STAT_NO_CABLE = 8'h48;

   // Reset values
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [6:0] FDD_IN_IDLE = 7'h7F;

   typedef enum logic [1:0] {
      OWN_MCU = 2'b00,
      OWN_FDC = 2'b01,
      OWN_HOST = 2'b10
   } ppmx_owner_t;

   typedef struct packed {
      ppmx_owner_t owner;
      logic [16:0] pin_out;
      logic [16:0] pin_oe_n;
      logic [6:0] fdd_in;
      logic [16:0] mcu_in;
      logic [7:0] data_wr;
      logic [7:0] data_rd;
      logic [7:0] ctrl_rd;
      logic [7:0] stat_rd;
   } ppmx_state_t;

endpackage

/* File: hdl/ppmx_fdd_map.sv */
`timescale 1ns/1ps
`default_nettype none
module ppmx_fdd_map (
   input wire logic enable,
   input wire logic dual_drive,
   input wire logic drive_swap,
   input wire logic drive0_select_n,
   input wire logic drive1_select_n,
   input wire logic motor0_on_n,
   input wire logic motor1_on_n,
   input wire logic write_pulse_n,
   input wire logic write_gate_n,
   input wire logic density_select,
   input wire logic head_select_n,
   input wire logic step_direction_n,
   input wire logic step_pulse_n,
   output logic [ppmx_pkg::NPINS-1:0] pin_out,
   output logic [ppmx_pkg::NPINS-1:0] pin_oe_n
);
   import ppmx_pkg::*;

   logic [16:0] level;
   logic [16:0] used;

   always_comb begin
      level = PINS_RELEASED;
      level[PIN_STB] = drive0_select_n; // [R13]
      level[PIN_D6] = motor0_on_n;
      level[PIN_ACK] = drive1_select_n;
      level[PIN_BUSY] = motor1_on_n;
      level[PIN_PE] = write_pulse_n;
      level[PIN_SLCT] = write_gate_n;
      level[PIN_ALF] = density_select;
      level[PIN_ERR] = head_select_n;
      level[PIN_INIT] = step_direction_n;
      level[PIN_SLIN] = step_pulse_n;
      used = FDD_FIXED_OUT_PINS;
      // Swap 0 puts drive 1 on the port, swap 1 puts drive 0 there
      if (dual_drive || drive_swap) begin // [R16] [R17] [R18]
         used = used | FDD_PAIR0_PINS;
      end
      if (dual_drive || !drive_swap) begin // [R16] [R17] [R18]
         used = used | FDD_PAIR1_PINS;
      end
      if (!enable) begin // [R19]
         used = PINS_ZERO;
      end
      // Only ever pull low; pull-ups are external
      pin_out = PINS_ZERO; // [R14]
      pin_oe_n = ~(used & ~level); // [R14]
   end
endmodule // ppmx_fdd_map
`default_nettype wire

/* File: sim/ppmx_port_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ppmx_port_model (
   input wire logic [ppmx_pkg::NPINS-1:0] pin_out,
   input wire logic [ppmx_pkg::NPINS-1:0] pin_oe_n,
   input wire logic [ppmx_pkg::NPINS-1:0] ext_out,
   input wire logic [ppmx_pkg::NPINS-1:0] ext_drive,
   output logic [ppmx_pkg::NPINS-1:0] pin_level
);
   import ppmx_pkg::*;
   // Pull-up on every line; wired-and, so a clash reads low
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         pin_level[i] = (pin_oe_n[i] | pin_out[i]) & (~ext_drive[i] | ext_out[i]);
      end
   end
endmodule // ppmx_port_model
`default_nettype wire

/* File: sim/ppmx_pin_mux_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ppmx_pin_mux_tb;
   import ppmx_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic hsel, fa, fpd, pa, ppd, swp, pg, en, mdd, hw;
   logic [1:0] mode;
   logic [9:0] f;
   logic [7:0] hwd, hdl, hcl, hsl, shadow, drd, crd, srd, e_d, e_c, e_s;
   logic [16:0] mcu_out, hpo, hpd, ext_out, ext_drv, pin_in, p_out, p_oe_n, m_in, e_drv, e_out, e_min;
   logic [6:0] fin, e_fin;
   ppmx_owner_t own, e_own;
   int err_count = 0;
   int num_checks = 0;

   always #2 mclk = ~mclk;

   ppmx_port_model ppmx_port_model_inst (.pin_out(p_out), .pin_oe_n(p_oe_n), .ext_out(ext_out),
      .ext_drive(ext_drv), .pin_level(pin_in));

   ppmx_pin_mux ppmx_pin_mux_inst (.MCLK(mclk), .RST(rst), .HOST_ACCESS_SELECT(hsel), .DEVICE_MODE(mode),
      .FDC_ACTIVE(fa), .FDC_POWER_DOWN(fpd), .PP_ACTIVE(pa), .PP_POWER_DOWN(ppd), .DRIVE_SWAP(swp),
      .VCC2_POWER_GOOD(pg), .MCU_PP_ENABLE(en), .MCU_PIN_OUT(mcu_out), .MCU_DATA_DRIVE(mdd),
      .HOST_PIN_OUT(hpo), .HOST_PIN_DRIVE(hpd), .HOST_DATA_WRITE(hw), .HOST_DATA_WDATA(hwd),
      .HOST_DATA_LD(hdl), .HOST_CTRL_LD(hcl), .HOST_STAT_LD(hsl), .DRIVE0_SELECT_N(f[0]),
      .DRIVE1_SELECT_N(f[1]), .MOTOR0_ON_N(f[2]), .MOTOR1_ON_N(f[3]), .WRITE_PULSE_N(f[4]),
      .WRITE_GATE_N(f[5]), .DENSITY_SELECT(f[6]), .HEAD_SELECT_N(f[7]), .STEP_DIRECTION_N(f[8]),
      .STEP_PULSE_N(f[9]), .PIN_IN(pin_in), .PIN_OUT(p_out), .PIN_OE_N(p_oe_n), .PIN_OWNER(own),
      .HOST_DATA_RD(drd), .HOST_CTRL_RD(crd), .HOST_STAT_RD(srd), .MCU_PIN_IN(m_in),
      .INDEX_PULSE_N(fin[0]), .TRACK_ZERO_N(fin[1]), .WRITE_PROTECT_N(fin[2]), .READ_PULSE_N(fin[3]),
      .DISK_CHANGED_N(fin[4]), .MEDIA_ID_BIT0(fin[5]), .MEDIA_ID_BIT1(fin[6]));

   task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Host select biased high so floppy and host owners come up often
   task automatic drive_rand();
      hsel <= ($urandom % 4) != 0;
      mode <= 2'($urandom);
      // Port DMA/IRQ parked by software outside this block, so activation stays free
      {fa, fpd, pa, ppd, swp, pg, en, mdd, hw} <= 9'($urandom);
      f <= 10'($urandom);
      {hwd, hdl, hcl, hsl} <= $urandom;
      mcu_out <= 17'($urandom);
      hpo <= 17'($urandom);
      hpd <= 17'($urandom);
      ext_out <= 17'($urandom);
      ext_drv <= 17'($urandom) & MCU_DATA_PINS;
   endtask

   // Expectations from the inputs taken at this edge
   task automatic predict();
      logic [16:0] lvl;
      lvl = PINS_ZERO;
      e_drv = PINS_ZERO;
      e_own = !hsel ? OWN_MCU : (mode == MODE_ONE_DRIVE || mode == MODE_TWO_DRIVE) ? OWN_FDC : OWN_HOST;
      case (e_own)
         OWN_MCU: begin
            e_drv = pg ? (MCU_OUT_PINS | (mdd ? MCU_DATA_PINS : PINS_ZERO)) : PINS_ZERO;
            lvl = mcu_out;
         end
         OWN_HOST: begin
            e_drv = (pa && !ppd && en) ? hpd : PINS_ZERO;
            lvl = hpo;
         end
         default: if (fa && !fpd) begin
            {e_drv[PIN_SLIN], e_drv[PIN_INIT], e_drv[PIN_ERR], e_drv[PIN_ALF], e_drv[PIN_SLCT],
               e_drv[PIN_PE]} = ~f[9:4];
            if (mode == MODE_TWO_DRIVE || swp) {e_drv[PIN_D6], e_drv[PIN_STB]} = ~{f[2], f[0]};
            if (mode == MODE_TWO_DRIVE || !swp) {e_drv[PIN_BUSY], e_drv[PIN_ACK]} = ~{f[3], f[1]};
         end
      endcase
      e_out = lvl & e_drv;
      e_d = (e_own == OWN_HOST) ? hdl : shadow;
      e_c = (e_own == OWN_HOST) ? hcl : CTRL_NO_CABLE;
      e_s = (e_own == OWN_HOST) ? hsl : STAT_NO_CABLE;
      e_fin = (e_own == OWN_FDC) ? {pin_in[PIN_D7], pin_in[PIN_D5:PIN_D0]} : FDD_IN_IDLE;
      e_min = pin_in;
      if (hw) shadow = hwd;
   endtask

   task automatic compare();
      chk("owner", 17'(e_own), 17'(own));
      chk("pin_oe_n", ~e_drv, p_oe_n);
      chk("pin_out", e_out, p_out & ~p_oe_n);
      chk("data_rd", 17'(e_d), 17'(drd));
      chk("ctrl_rd", 17'(e_c), 17'(crd));
      chk("stat_rd", 17'(e_s), 17'(srd));
      chk("floppy_in", 17'(e_fin), 17'(fin));
      chk("mcu_pin_in", e_min, m_in);
   endtask

   task automatic reset_check();
      rst <= 1'b1;
      #1;
      chk("rst_oe_n", PINS_RELEASED, p_oe_n);
      chk("rst_rd", {1'b0, CTRL_NO_CABLE, STAT_NO_CABLE}, {1'b0, crd, srd});
      chk("rst_data", 17'(BYTE_ZERO), 17'(drd));
      chk("rst_owner_in", {8'h00, 2'(OWN_MCU), FDD_IN_IDLE}, {8'h00, 2'(own), fin});
      chk("rst_pins", PINS_ZERO, p_out | m_in);
      repeat (4) @(posedge mclk);
      // Release between edges so no assertion attempt starts on reset outputs
      @(negedge mclk);
      rst <= 1'b0;
      shadow = BYTE_ZERO;
   endtask

   initial begin
      {hsel, fa, fpd, pa, ppd, swp, pg, en, mdd, hw, mode, f} = '0;
      {hwd, hdl, hcl, hsl, mcu_out, hpo, hpd, ext_out, ext_drv} = '0;
      shadow = BYTE_ZERO;
      void'($urandom(32'h9E3EA47D));
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      rst <= 1'b0;
      for (int n = 0; n < 4000; n++) begin
         @(posedge mclk);
         predict();
         drive_rand();
         #1;
         compare();
         if (n == 2000) reset_check();
      end
      print_verdict();
   end

   // Run needs about 4000 cycles; twice that means a hang
   initial begin
      #(4 * 8000);
      err_count++;
      print_verdict();
   end
endmodule // ppmx_pin_mux_tb
`default_nettype wire
